// file: hw/mxt_exec.v
// Execution slice for six instructions of an 8-bit microcontroller core.
// Assumes decoded op pulses, a one-cycle ROM read and a one-cycle file register read.
`timescale 1ns/10ps
`default_nettype none
`include "mxt_regs.vh"

module mxt_exec (
    input  wire                       sys_clk,
    input  wire                       srst,
    input  wire                       op_valid,
    input  wire [2:0]                 op_code,
    input  wire [7:0]                 op_imm,
    input  wire [5:0]                 op_file_idx,
    input  wire                       op_dest,
    input  wire [2:0]                 table_addr_high,
    input  wire [7:0]                 file_rdata,
    input  wire [13:0]                rom_rdata,
    output reg                        busy,
    output reg                        done,
    output reg  [7:0]                 accumulator,
    output reg  [5:0]                 table_data_high,
    output reg  [7:0]                 timer0_mode_reg,
    output reg                        zero_flag,
    output reg                        digit_carry_flag,
    output reg                        carry_flag,
    output reg                        rom_rd_en,
    output reg  [10:0]                rom_addr,
    output reg  [5:0]                 file_addr,
    output reg                        file_we,
    output reg  [7:0]                 file_wdata
);

    localparam ST_IDLE  = 1'b0;
    localparam ST_TABLE = 1'b1;

    reg        state_r;
    reg        state_nxt;
    wire [7:0] diff;
    wire       sub_c;
    wire       sub_dc;
    wire [7:0] xor_res;
    wire [7:0] xor_operand;
    wire       take;

    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    assign take        = op_valid && (state_r == ST_IDLE);
    assign xor_operand = (op_code == `MXT_OP_XOR_FILE) ? file_rdata : op_imm;

    mxt_alu u_alu (
        .minuend     (op_imm),
        .subtrahend  (accumulator),
        .xor_a       (accumulator),
        .xor_b       (xor_operand),
        .diff        (diff),
        .carry       (sub_c),
        .digit_carry (sub_dc),
        .xor_res     (xor_res)
    );

    // ****************************************
    // State sequencing
    // ****************************************
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (take && op_code == `MXT_OP_TABLE_READ) begin
                    state_nxt = ST_TABLE;                               // see RULE2
                end
            end
            ST_TABLE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Datapath registers
    // ****************************************
    always @(posedge sys_clk) begin
        if (srst) begin
            state_r          <= ST_IDLE;
            busy             <= 1'b0;
            done             <= 1'b0;
            accumulator      <= `MXT_ACC_RST;
            table_data_high  <= `MXT_TBH_RST;
            timer0_mode_reg  <= `MXT_T0MODE_RST;
            zero_flag        <= 1'b0;
            digit_carry_flag <= 1'b0;
            carry_flag       <= 1'b0;
            rom_rd_en        <= 1'b0;
            rom_addr         <= 11'h000;
            file_addr        <= 6'h00;
            file_we          <= 1'b0;
            file_wdata       <= 8'h00;
        end else begin
            state_r   <= state_nxt;
            done      <= 1'b0;
            file_we   <= 1'b0;
            rom_rd_en <= 1'b0;
            busy      <= (state_nxt == ST_TABLE);
            file_addr <= op_file_idx;
            if (state_r == ST_TABLE) begin
                accumulator     <= rom_rdata[7:0];                      // see RULE2
                table_data_high <= rom_rdata[13:8];                     // see RULE3
                done            <= 1'b1;
            end else if (take) begin
                case (op_code)
                    `MXT_OP_SUB_IMM: begin
                        accumulator      <= diff;                       // see RULE1
                        zero_flag        <= is_zero(diff);
                        digit_carry_flag <= sub_dc;
                        carry_flag       <= sub_c;                      // see RULE9
                        done             <= 1'b1;
                    end
                    `MXT_OP_TABLE_READ: begin
                        rom_addr  <= {table_addr_high, accumulator};    // see RULE2
                        rom_rd_en <= 1'b1;
                    end
                    `MXT_OP_LOAD_T0MODE: begin
                        timer0_mode_reg <= accumulator;                 // see RULE4
                        done            <= 1'b1;
                    end
                    `MXT_OP_READ_T0MODE: begin
                        accumulator <= timer0_mode_reg;                 // see RULE5
                        done        <= 1'b1;
                    end
                    `MXT_OP_XOR_FILE: begin
                        zero_flag <= is_zero(xor_res);                  // see RULE7
                        if (op_dest) begin
                            file_we    <= 1'b1;                         // see RULE6
                            file_wdata <= xor_res;
                        end else begin
                            accumulator <= xor_res;                     // see RULE6
                        end
                        done <= 1'b1;
                    end
                    `MXT_OP_XOR_IMM: begin
                        accumulator <= xor_res;                         // see RULE8
                        zero_flag   <= is_zero(xor_res);
                        done        <= 1'b1;
                    end
                    default: begin
                        done <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // mxt_exec

`default_nettype wire

// file: common/mxt_regs.vh
// Constants for the execution slice: opcodes, field widths, reset values.
// Assumes it is included by bare name from the design files.
// What this block does
// (RULE1) Immediate minus accumulator goes to accumulator; zero, digit carry, carry updated; one cycle.
// (RULE2) Table read addresses {table_addr_high[2:0], accumulator}; low byte to accumulator; two cycles.
// (RULE3) Table read puts word bits 13..8 into table_data_high[5:0]; no flags change.
// (RULE4) Load timer mode copies accumulator to timer0_mode_reg; no flags, accumulator kept.
// (RULE5) Read timer mode copies timer0_mode_reg into accumulator in one cycle; no flags.
// (RULE6) Register XOR takes index 0..63 and destination bit: 0 accumulator, 1 file register.
// (RULE7) Register XOR computes accumulator XOR file register, updates only Z, one cycle.
// (RULE8) Immediate XOR stores accumulator XOR immediate in accumulator, only Z, one cycle.
// (RULE9) Subtraction carry is not-borrow: set when minuend is at least subtrahend.
`ifndef MXT_REGS_VH
`define MXT_REGS_VH

// ****************************************
// Operation codes
// ****************************************
`define MXT_OP_W            3
`define MXT_OP_NONE         3'h0
`define MXT_OP_SUB_IMM      3'h1
`define MXT_OP_TABLE_READ   3'h2
`define MXT_OP_LOAD_T0MODE  3'h3
`define MXT_OP_READ_T0MODE  3'h4
`define MXT_OP_XOR_FILE     3'h5
`define MXT_OP_XOR_IMM      3'h6

// ****************************************
// Widths and reset values
// ****************************************
`define MXT_DATA_W          8
`define MXT_FILE_ADDR_W     6
`define MXT_ROM_ADDR_W      11
`define MXT_ROM_DATA_W      14
`define MXT_TBH_W           6
`define MXT_ACC_RST         8'h00
`define MXT_T0MODE_RST      8'h00
`define MXT_TBH_RST         6'h00
`define MXT_TABLE_CYCLES    2

`endif

// file: hw/mxt_alu.v
// Arithmetic unit: subtraction with flags and exclusive-OR.
// Assumes purely combinational use by the execution slice.
`timescale 1ns/10ps
`default_nettype none
`include "mxt_regs.vh"

module mxt_alu (
    input  wire [7:0] minuend,
    input  wire [7:0] subtrahend,
    input  wire [7:0] xor_a,
    input  wire [7:0] xor_b,
    output wire [7:0] diff,
    output wire       carry,
    output wire       digit_carry,
    output wire [7:0] xor_res
);

    wire [8:0] full_diff;
    wire [4:0] low_diff;

    // ****************************************
    // Subtraction
    // ****************************************
    assign full_diff   = {1'b0, minuend} - {1'b0, subtrahend};          // see RULE1
    assign low_diff    = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
    assign diff        = full_diff[7:0];
    assign carry       = ~full_diff[8];                                 // see RULE9
    assign digit_carry = ~low_diff[4];

    // ****************************************
    // Exclusive-OR
    // ****************************************
    assign xor_res = xor_a ^ xor_b;                                     // see RULE7

endmodule // mxt_alu

`default_nettype wire

// file: test/mxt_exec_chk.sv
// Checker for the execution slice, bound to the top module's ports.
// Assumes the slice's opcodes from its header and a synchronous high reset.
`timescale 1ns/10ps
`default_nettype none
`include "mxt_regs.vh"
module mxt_exec_chk (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        op_valid,
    input wire logic [2:0]  op_code,
    input wire logic [7:0]  op_imm,
    input wire logic [5:0]  op_file_idx,
    input wire logic        op_dest,
    input wire logic [2:0]  table_addr_high,
    input wire logic [7:0]  file_rdata,
    input wire logic [13:0] rom_rdata,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [7:0]  accumulator,
    input wire logic [5:0]  table_data_high,
    input wire logic [7:0]  timer0_mode_reg,
    input wire logic        zero_flag,
    input wire logic        digit_carry_flag,
    input wire logic        carry_flag,
    input wire logic        rom_rd_en,
    input wire logic [10:0] rom_addr,
    input wire logic [5:0]  file_addr,
    input wire logic        file_we,
    input wire logic [7:0]  file_wdata
);
    // ****************************************
    // Taken requests and sequences
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire logic [2:0] fl = {zero_flag, digit_carry_flag, carry_flag};
    function automatic logic tk(input logic [2:0] c);
        return op_valid && !busy && op_code == c;
    endfunction
    sequence s_rom_issue;
        rom_rd_en && busy && rom_addr == {$past(table_addr_high), $past(accumulator)};
    endsequence
    sequence s_rom_land;
        done && !busy && accumulator == $past(rom_rdata[7:0]);
    endsequence
    // ****************************************
    // Assertions
    // ****************************************
    a_sub_result: assert property (tk(`MXT_OP_SUB_IMM) |=> done &&
        accumulator == 8'($past(op_imm) - $past(accumulator))) else $error("sub result");
    a_sub_carry: assert property (tk(`MXT_OP_SUB_IMM) |=>
        carry_flag == ($past(op_imm) >= $past(accumulator))) else $error("sub carry");
    a_sub_flags: assert property (tk(`MXT_OP_SUB_IMM) |=>
        zero_flag == (accumulator == 8'h00) &&
        digit_carry_flag == ($past(op_imm[3:0]) >= $past(accumulator[3:0]))) else $error("sub flags");
    a_table_steps: assert property (tk(`MXT_OP_TABLE_READ) |=> s_rom_issue ##1 s_rom_land)
        else $error("table read steps");
    a_table_high: assert property (rom_rd_en |=> table_data_high == $past(rom_rdata[13:8])
        && $stable(fl)) else $error("table high byte");
    a_mode_load: assert property (tk(`MXT_OP_LOAD_T0MODE) |=> timer0_mode_reg ==
        $past(accumulator) && $stable(accumulator) && $stable(fl)) else $error("mode load");
    a_mode_read: assert property (tk(`MXT_OP_READ_T0MODE) |=> done && $stable(fl) &&
        accumulator == $past(timer0_mode_reg)) else $error("mode read");
    a_xor_dest: assert property (tk(`MXT_OP_XOR_FILE) |=> file_we == $past(op_dest)
        && file_addr == $past(op_file_idx)) else $error("xor destination");
    a_xor_file: assert property (tk(`MXT_OP_XOR_FILE) |=> ($past(op_dest) ? file_wdata :
        accumulator) == ($past(accumulator) ^ $past(file_rdata)) && done && $stable(fl[1:0])
        && zero_flag == (($past(accumulator) ^ $past(file_rdata)) == 8'h00))
        else $error("xor file value");
    a_xor_imm: assert property (tk(`MXT_OP_XOR_IMM) |=> done && $stable(fl[1:0]) &&
        zero_flag == (accumulator == 8'h00) && accumulator == ($past(accumulator) ^ $past(op_imm)))
        else $error("xor immediate");
endmodule // mxt_exec_chk
bind mxt_exec mxt_exec_chk u_chk (.*);
`default_nettype wire

// file: test/mcu_exec_subset_xor_table_read_tb_top.sv
// Self-checking bench for the execution slice.
// Assumes the bench acts as ROM and register file, driving inputs at the falling edge.
`timescale 1ns/10ps
`default_nettype none
`include "mxt_regs.vh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module mcu_exec_subset_xor_table_read_tb_top;
    logic sys_clk = 0, srst = 1, op_valid = 0, op_dest = 0;
    logic [2:0] op_code = 0, table_addr_high = 0;
    logic [7:0] op_imm = 0, file_rdata = 0, ea, accu, tmr, fwd;
    logic [5:0] op_file_idx = 0, tdh, fad;
    logic [10:0] rad;
    logic busy, done, zf, dcf, cf, rre, fwe;
    int fails = 0, checks_done = 0;
    wire logic [13:0] rw = {rad[10:5], rad[7:0] ^ 8'hA5};
    wire logic [13:0] rom_rdata = busy ? rw : ~rw;
    always #2.5 sys_clk = ~sys_clk;
    mxt_exec dut (.sys_clk(sys_clk), .srst(srst), .op_valid(op_valid), .op_code(op_code),
        .op_imm(op_imm), .op_file_idx(op_file_idx), .op_dest(op_dest),
        .table_addr_high(table_addr_high), .file_rdata(file_rdata), .rom_rdata(rom_rdata),
        .busy(busy), .done(done), .accumulator(accu), .table_data_high(tdh),
        .timer0_mode_reg(tmr), .zero_flag(zf), .digit_carry_flag(dcf), .carry_flag(cf),
        .rom_rd_en(rre), .rom_addr(rad), .file_addr(fad), .file_we(fwe), .file_wdata(fwd));
    // ****************************************
    // Scenario tasks
    // ****************************************
    task automatic op(input [2:0] c, input [7:0] i, input [5:0] x, input d, input [7:0] fr);
        @(negedge sys_clk);
        {op_valid, op_code, op_imm, op_file_idx, op_dest, file_rdata} = {1'b1, c, i, x, d, fr};
        @(negedge sys_clk);
        op_valid = 0;
        file_rdata = ~fr;
    endtask
    task automatic set_accu(input [7:0] v);
        op(`MXT_OP_XOR_IMM, v ^ ea, 6'h00, 1'b0, 8'h00);
        `CHK("accu", v, accu)
        ea = v;
    endtask
    task automatic t_sub;
        logic [7:0] m[3] = '{8'h05, 8'h06, 8'h01};
        logic [7:0] a[3] = '{8'h06, 8'h05, 8'h01};
        for (int k = 0; k < 3; k++) begin
            set_accu(a[k]);
            op(`MXT_OP_SUB_IMM, m[k], 6'h00, 1'b0, 8'h00);
            ea = m[k] - a[k];
            `CHK("sub accu", ea, accu)
            `CHK("sub done", 1'b1, done)
            `CHK("sub c", m[k] >= a[k], cf)
            `CHK("sub digit carry", m[k][3:0] >= a[k][3:0], dcf)
            `CHK("sub z", ea == 8'h00, zf)
        end
    endtask
    task automatic t_table;
        set_accu(8'hA5);
        table_addr_high = 3'h2;
        @(negedge sys_clk);
        {op_valid, op_code} = {1'b1, `MXT_OP_TABLE_READ};
        @(negedge sys_clk);
        `CHK("rom addr", 11'h2A5, rad)
        `CHK("rom rd", 1'b1, rre)
        `CHK("busy", 1'b1, busy)
        {op_code, op_imm} = {`MXT_OP_XOR_IMM, 8'hFF};
        @(negedge sys_clk);
        op_valid = 0;
        ea = 8'h00;
        `CHK("tbl accu", ea, accu)
        `CHK("tbl done", 1'b1, done)
        `CHK("busy off", 1'b0, busy)
        `CHK("tbl high", 6'h15, tdh)
        `CHK("tbl z", 1'b0, zf)
        `CHK("tbl c", 1'b1, cf)
    endtask
    task automatic t_mode;
        set_accu(8'hAA);
        op(`MXT_OP_LOAD_T0MODE, 8'h00, 6'h00, 1'b0, 8'h00);
        `CHK("mode", 8'hAA, tmr)
        `CHK("mode accu", 8'hAA, accu)
        set_accu(8'h55);
        op(`MXT_OP_READ_T0MODE, 8'h00, 6'h00, 1'b0, 8'h00);
        ea = 8'hAA;
        `CHK("rd mode", 8'hAA, accu)
        `CHK("rd mode done", 1'b1, done)
    endtask
    task automatic t_xfile;
        set_accu(8'hF0);
        op(`MXT_OP_XOR_FILE, 8'h00, 6'h3F, 1'b1, 8'hA5);
        `CHK("we", 1'b1, fwe)
        `CHK("faddr", 6'h3F, fad)
        `CHK("fwdata", 8'h55, fwd)
        `CHK("accu kept", 8'hF0, accu)
        op(`MXT_OP_XOR_FILE, 8'h00, 6'h00, 1'b0, 8'hF0);
        `CHK("we0", 1'b0, fwe)
        `CHK("xor accu", 8'h00, accu)
        `CHK("xor z", 1'b1, zf)
        ea = 8'h00;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000 fails++;
        report_and_stop();
    end
    initial begin
        ea = 8'h00;
        repeat (5) @(negedge sys_clk);
        srst = 0;
        `CHK("rst accu", 8'h00, accu)
        t_sub();
        t_table();
        t_mode();
        t_xfile();
        report_and_stop();
    end
endmodule // mcu_exec_subset_xor_table_read_tb_top
`default_nettype wire
